/* File: rtl/pim_defs.svh */
// Offsets, field positions, reset values and timing counts of the image mode block.
// Assumes the includer has a 16-bit register word and a 4-bit register address.
`ifndef PIM_DEFS_SVH
`define PIM_DEFS_SVH

// ****************************************
// Register offsets (word index)
// ****************************************
`define PIM_OFS_MODE 4'h0
`define PIM_OFS_SPARE 4'h1
`define PIM_OFS_HMARGIN 4'h2
`define PIM_OFS_LINELEN 4'h3
`define PIM_OFS_VTOP 4'h4
`define PIM_OFS_VBOT 4'h5
`define PIM_OFS_STATUS 4'h6

// ****************************************
// Fields of mode_control; top bit of horizontal margin
// ****************************************
`define PIM_F_MODE_HI 3
`define PIM_F_MODE_LO 0
`define PIM_F_VIDKILL 7
`define PIM_F_BDEDGE 8
`define PIM_F_VIDPOL 9
`define PIM_F_FSYNC_EN 10
`define PIM_F_MARGIN_HI 10

// ****************************************
// Reset values
// ****************************************
`define PIM_RST_MODE 16'h0000
`define PIM_RST_WORD 16'h0000

// ****************************************
// Timing
// ****************************************
`define PIM_CLK_NS 10
`define PIM_SYNC_STAGES 3

`endif

/* File: rtl/pim_pkg.sv */
// Types shared by the image mode block.
// Assumes nothing of its surroundings.
package pim_pkg;

    typedef enum logic [3:0] {
        PIM_MODE_300 = 4'h4,
        PIM_MODE_300_TEST = 4'h5,
        PIM_MODE_200 = 4'h6,
        PIM_MODE_200_TEST = 4'h7,
        PIM_MODE_200X100 = 4'h8,
        PIM_MODE_200X100_TEST = 4'h9,
        PIM_MODE_600X8 = 4'hb,
        PIM_MODE_300X8 = 4'hc
    } pim_mode_t;

    // Page sequencer: idle, armed, top margin, imaging, done
    typedef enum logic [2:0] {
        PIM_PG_IDLE = 3'b000,
        PIM_PG_ARMED = 3'b001,
        PIM_PG_TOP = 3'b011,
        PIM_PG_IMAGE = 3'b010,
        PIM_PG_DONE = 3'b110
    } pim_page_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pim_bus_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
        logic enhance;
        logic eight_bit;
    } pim_video_t;

endpackage

/* File: rtl/pim_mode_ctrl.sv */
// Mode configuration, page/line sequencing and video path of the image enhancement block.
// Assumes a 100 MHz core clock; video clock, beam detect and syncs arrive asynchronously.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "pim_defs.svh"

module pim_mode_ctrl #(
    parameter int DOT_CYCLES = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire pim_pkg::pim_bus_req_t bus_req,
    output logic [15:0] bus_rdata,
    // Engine inputs
    input wire logic video_clk,
    input wire logic [7:0] video_data,
    input wire logic beam_detect,
    input wire logic page_sync,
    input wire logic line_sync,
    // Modulator output
    output pim_pkg::pim_video_t mod_out,
    output logic transfer_active
);
    import pim_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] mode_control_reg;
    logic [10:0] horizontal_margin_reg;
    logic [10:0] line_length_reg;
    logic [15:0] vertical_top_margin_reg;
    logic [15:0] vertical_bottom_margin_reg;
    logic [15:0] line_count_reg;
    pim_page_t page_reg;
    logic [15:0] rdata_next;

    // Spare register and bits 15:11 of margin and line length are dropped on write; mode_control keeps all 16 bits
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mode_control_reg <= `PIM_RST_MODE;
            horizontal_margin_reg <= '0;
            line_length_reg <= '0;
            vertical_top_margin_reg <= `PIM_RST_WORD;
            vertical_bottom_margin_reg <= `PIM_RST_WORD;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                `PIM_OFS_MODE: mode_control_reg <= bus_req.wdata;
                `PIM_OFS_HMARGIN: horizontal_margin_reg <= bus_req.wdata[10:0];
                `PIM_OFS_LINELEN: line_length_reg <= bus_req.wdata[10:0];
                `PIM_OFS_VTOP: vertical_top_margin_reg <= bus_req.wdata;
                `PIM_OFS_VBOT: vertical_bottom_margin_reg <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_next = 16'h0000;
        unique case (bus_req.addr)
            `PIM_OFS_MODE: rdata_next = mode_control_reg;
            `PIM_OFS_HMARGIN: rdata_next = {5'h00, horizontal_margin_reg};
            `PIM_OFS_LINELEN: rdata_next = {5'h00, line_length_reg};
            `PIM_OFS_VTOP: rdata_next = vertical_top_margin_reg;
            `PIM_OFS_VBOT: rdata_next = vertical_bottom_margin_reg;
            `PIM_OFS_STATUS: rdata_next = {line_count_reg[12:0], page_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bus_rdata <= 16'h0000;
        end else if (bus_req.rd) begin
            bus_rdata <= rdata_next;
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    // ****************************************
    // Mode decode
    // ****************************************
    logic [3:0] mode_field;
    logic mode_one_bit;
    logic mode_test;
    logic mode_eight;
    logic bd_falling;
    logic vid_invert;
    logic fsync_arm;
    assign mode_field = mode_control_reg[`PIM_F_MODE_HI:`PIM_F_MODE_LO];
    assign bd_falling = mode_control_reg[`PIM_F_BDEDGE];
    assign vid_invert = mode_control_reg[`PIM_F_VIDPOL];
    assign fsync_arm = mode_control_reg[`PIM_F_FSYNC_EN];

    always_comb begin
        mode_one_bit = 1'b0;
        mode_test = 1'b0;
        mode_eight = 1'b0;
        unique case (mode_field)
            PIM_MODE_300, PIM_MODE_200, PIM_MODE_200X100: mode_one_bit = 1'b1;
            PIM_MODE_300_TEST, PIM_MODE_200_TEST, PIM_MODE_200X100_TEST: begin
                mode_one_bit = 1'b1;
                mode_test = 1'b1;
            end
            PIM_MODE_600X8, PIM_MODE_300X8: mode_eight = 1'b1;
            default: ;
        endcase
    end

    // ****************************************
    // Input synchronisers: 3 stages, change counts when stages 2 and 3 agree
    // ****************************************
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync_stable;
    logic [NSYNC-1:0] sync_prev;
    logic [7:0] data_s1_reg;
    logic [7:0] data_s2_reg;
    logic [7:0] data_s3_reg;
    assign sync_in = {line_sync, page_sync, beam_detect, video_clk};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            logic [`PIM_SYNC_STAGES-1:0] sh_reg;
            logic st_reg;
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    sh_reg <= '0;
                    st_reg <= 1'b0;
                end else begin
                    sh_reg <= {sh_reg[1:0], sync_in[gi]};
                    if (sh_reg[1] == sh_reg[2]) begin
                        st_reg <= sh_reg[2];
                    end
                end
            end
            assign sync_stable[gi] = st_reg;
        end
    endgenerate

    // Data passes three stages but needs no agreement test: it is read only
    // several cycles after the video clock edge, long after it has settled
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            data_s1_reg <= 8'h00;
            data_s2_reg <= 8'h00;
            data_s3_reg <= 8'h00;
            sync_prev <= '0;
        end else begin
            data_s1_reg <= video_data;
            data_s2_reg <= data_s1_reg;
            data_s3_reg <= data_s2_reg;
            sync_prev <= sync_stable;
        end
    end

    logic vclk_rise;
    logic bd_edge;
    logic page_rise;
    logic line_rise;
    assign vclk_rise = sync_stable[0] & ~sync_prev[0];
    assign bd_edge = bd_falling ? (~sync_stable[1] & sync_prev[1]) : (sync_stable[1] & ~sync_prev[1]);
    assign page_rise = sync_stable[2] & ~sync_prev[2];
    assign line_rise = sync_stable[3] & ~sync_prev[3];

    // ****************************************
    // Page sequencer
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            page_reg <= PIM_PG_IDLE;
            line_count_reg <= 16'h0000;
        end else if (!fsync_arm) begin
            page_reg <= PIM_PG_IDLE;
            line_count_reg <= 16'h0000;
        end else begin
            unique case (page_reg)
                PIM_PG_IDLE: page_reg <= PIM_PG_ARMED;
                PIM_PG_ARMED: begin
                    if (page_rise) begin
                        page_reg <= PIM_PG_TOP;
                    end
                end
                PIM_PG_TOP: begin
                    if (line_count_reg == vertical_top_margin_reg) begin
                        page_reg <= PIM_PG_IMAGE;
                    end else if (line_rise) begin
                        line_count_reg <= line_count_reg + 16'h0001;
                    end
                end
                PIM_PG_IMAGE: begin
                    if (line_count_reg == vertical_bottom_margin_reg) begin
                        page_reg <= PIM_PG_DONE;
                    end else if (line_rise) begin
                        line_count_reg <= line_count_reg + 16'h0001;
                    end
                end
                PIM_PG_DONE: ;
            endcase
        end
    end

    // ****************************************
    // Line timing: horizontal margin, then line length plus one bytes
    // ****************************************
    logic [10:0] hpos_reg;
    logic [10:0] byte_count_reg;
    logic [$clog2(DOT_CYCLES+1)-1:0] dot_reg;
    logic in_margin_reg;
    logic in_line_reg;
    logic take_byte;
    assign take_byte = in_line_reg & vclk_rise & (page_reg == PIM_PG_IMAGE);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            hpos_reg <= '0;
            dot_reg <= '0;
            in_margin_reg <= 1'b0;
            in_line_reg <= 1'b0;
            byte_count_reg <= '0;
        end else if (bd_edge) begin
            // Margin restarts at the selected edge in every mode
            hpos_reg <= '0;
            dot_reg <= '0;
            in_margin_reg <= 1'b1;
            in_line_reg <= 1'b0;
            byte_count_reg <= '0;
        end else if (in_margin_reg) begin
            if (hpos_reg == horizontal_margin_reg) begin
                in_margin_reg <= 1'b0;
                in_line_reg <= 1'b1;
            end else if (dot_reg == DOT_CYCLES[$bits(dot_reg)-1:0] - 1'b1) begin
                dot_reg <= '0;
                hpos_reg <= hpos_reg + 11'h001;
            end else begin
                dot_reg <= dot_reg + 1'b1;
            end
        end else if (take_byte) begin
            // In 300x8 one 300 dpi line is counted, host sizes it
            if (byte_count_reg == line_length_reg) begin
                in_line_reg <= 1'b0;
            end else begin
                byte_count_reg <= byte_count_reg + 11'h001;
            end
        end
    end

    // ****************************************
    // Video output path
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mod_out <= '0;
            transfer_active <= 1'b0;
        end else begin
            transfer_active <= (page_reg == PIM_PG_IMAGE);
            mod_out.valid <= take_byte & (mode_one_bit | mode_eight);
            mod_out.eight_bit <= mode_eight;
            // Test modes skip enhancement and keep the bitmap untouched
            mod_out.enhance <= mode_one_bit & ~mode_test;
            if (take_byte) begin
                mod_out.data <= mode_test ? data_s3_reg : (data_s3_reg ^ {8{vid_invert}});
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_test_bypass: assert property (@(posedge core_clk) disable iff (!resetn)
        $past(take_byte) && $past(mode_test) |-> mod_out.data == $past(data_s3_reg) && !mod_out.enhance)
        else $error("test mode altered data");
    chk_polarity_out: assert property (@(posedge core_clk) disable iff (!resetn)
        $past(take_byte) && !$past(mode_test) |-> mod_out.data == ($past(data_s3_reg) ^ {8{$past(vid_invert)}}))
        else $error("polarity wrong");
    chk_eight_decode: assert property (@(posedge core_clk) disable iff (!resetn)
        (mode_field == 4'hb || mode_field == 4'hc) |=> mod_out.eight_bit)
        else $error("eight bit mode not decoded");
    chk_one_decode: assert property (@(posedge core_clk) disable iff (!resetn)
        mode_one_bit == (mode_field inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9}))
        else $error("one bit decode wrong");
    chk_page_start: assert property (@(posedge core_clk) disable iff (!resetn)
        page_reg == PIM_PG_ARMED && page_rise && fsync_arm |=> page_reg == PIM_PG_TOP)
        else $error("page sync missed");
    chk_top_reach: assert property (@(posedge core_clk) disable iff (!resetn)
        page_reg == PIM_PG_TOP && fsync_arm && line_count_reg == vertical_top_margin_reg |=> page_reg == PIM_PG_IMAGE)
        else $error("top margin not honoured");
    chk_bot_reach: assert property (@(posedge core_clk) disable iff (!resetn)
        page_reg == PIM_PG_IMAGE && fsync_arm && line_count_reg == vertical_bottom_margin_reg |=> page_reg == PIM_PG_DONE)
        else $error("bottom margin not honoured");
    chk_disarm_idle: assert property (@(posedge core_clk) disable iff (!resetn)
        !fsync_arm |=> page_reg == PIM_PG_IDLE && line_count_reg == 16'h0000)
        else $error("disarm did not idle");
    chk_margin_restart: assert property (@(posedge core_clk) disable iff (!resetn)
        bd_edge |=> hpos_reg == 11'h000 && in_margin_reg && !in_line_reg)
        else $error("margin not restarted");
    chk_no_data_margin: assert property (@(posedge core_clk) disable iff (!resetn)
        in_margin_reg |=> !mod_out.valid)
        else $error("data during margin");
    chk_hm_upper: assert property (@(posedge core_clk) disable iff (!resetn)
        bus_req.wr && bus_req.addr == `PIM_OFS_HMARGIN |=> horizontal_margin_reg == $past(bus_req.wdata[10:0]))
        else $error("margin write wrong");
    chk_valid_region: assert property (@(posedge core_clk) disable iff (!resetn)
        mod_out.valid |-> $past(page_reg) == PIM_PG_IMAGE && $past(in_line_reg))
        else $error("byte outside imaging line");
    chk_disarm_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
        !fsync_arm ##1 !fsync_arm |=> !transfer_active)
        else $error("imaging while disarmed");
    chk_hm_read: assert property (@(posedge core_clk) disable iff (!resetn)
        bus_req.rd && bus_req.addr == `PIM_OFS_HMARGIN |=> bus_rdata[15:11] == 5'h00)
        else $error("margin upper bits read back");

    cov_page_done: cover property (@(posedge core_clk) disable iff (!resetn) page_reg == PIM_PG_DONE);
    cov_test_byte: cover property (@(posedge core_clk) disable iff (!resetn) take_byte && mode_test);
    cov_eight_byte: cover property (@(posedge core_clk) disable iff (!resetn) take_byte && mode_eight);
    cov_fall_edge: cover property (@(posedge core_clk) disable iff (!resetn) bd_edge && bd_falling);

endmodule

/* File: tb/pim_engine_model.sv */
// Behavioural print engine: page sync, line syncs, beam detect and the parallel video byte stream.
// Assumes the bench raises start once per page and holds bd_fall steady for the whole page.
`timescale 1ns/10ps

module pim_engine_model #(
    parameter int LINES = 4,
    parameter int BYTES = 6
) (
    // Bench control
    input wire logic start,
    input wire logic bd_fall,
    // Engine pins
    output logic video_clk,
    output logic [7:0] video_data,
    output logic beam_detect,
    output logic page_sync,
    output logic line_sync
);
    // ****************************************
    // Page generator
    // ****************************************
    initial begin
        video_clk = 1'b0;
        video_data = 8'h00;
        beam_detect = 1'b0;
        page_sync = 1'b0;
        line_sync = 1'b0;
    end

    // Video clock stands still between lines; data is changed on its falling edge
    always @(posedge start) begin
        // Keep every pin change off the core clock edges
        #2;
        beam_detect = bd_fall;
        page_sync = 1'b1;
        for (int l = 0; l < LINES; l++) begin
            #300 line_sync = 1'b1;
            #200 line_sync = 1'b0;
            #100 beam_detect = ~bd_fall;
            #300;
            for (int k = 0; k < BYTES; k++) begin
                video_data = 8'h30 + 8'(k);
                // Second edge of opposite sense lands inside the byte burst on purpose
                if (k == 3) beam_detect = bd_fall;
                #80 video_clk = 1'b1;
                #80 video_clk = 1'b0;
            end
            // Released bus shows the inverse of its last value
            video_data = ~video_data;
        end
        #300 page_sync = 1'b0;
    end
endmodule

/* File: tb/test_print_image_mode_config.sv */
// Self-checking bench: register table, mode decode, page sequencing and video path.
// Assumes pim_engine_model on the engine pins and registers at word indices 0 to 6.
`timescale 1ns/10ps
`include "pim_defs.svh"

module test_print_image_mode_config;
    import pim_pkg::*;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic [15:0] rexp;
        logic enh;
        logic e8;
    } pim_row_t;

    logic core_clk;
    logic resetn;
    pim_bus_req_t bus_req;
    logic [15:0] bus_rdata;
    logic video_clk;
    logic [7:0] video_data;
    logic beam_detect;
    logic page_sync;
    logic line_sync;
    pim_video_t mod_out;
    logic transfer_active;
    logic start;
    logic bd_fall;
    logic exp_inv;
    int n_valid;
    int err_count;
    int samples_checked;
    pim_row_t rows [15];

    pim_mode_ctrl #(.DOT_CYCLES(4)) DUT (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .video_clk(video_clk), .video_data(video_data), .beam_detect(beam_detect),
        .page_sync(page_sync), .line_sync(line_sync), .mod_out(mod_out), .transfer_active(transfer_active));

    pim_engine_model #(.LINES(4), .BYTES(6)) engine (.start(start), .bd_fall(bd_fall), .video_clk(video_clk),
        .video_data(video_data), .beam_detect(beam_detect), .page_sync(page_sync), .line_sync(line_sync));

    // ****************************************
    // Helpers
    // ****************************************
    always #5 core_clk = ~core_clk;

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // Each access lets one edge pass after dropping its strobe, so no strobe is set twice in a time step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        @(posedge core_clk);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] mask);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk("bus_rdata", exp, bus_rdata & mask);
        @(posedge core_clk);
    endtask

    // Margins stay programmed across pages; 4 bytes per line, first byte eaten by the margin
    task automatic page(input logic [15:0] mode, input int exp_n, input logic inv, input logic [2:0] st);
        wr(`PIM_OFS_MODE, mode);
        exp_inv = inv;
        n_valid = 0;
        bd_fall <= mode[`PIM_F_BDEDGE];
        start <= 1'b1;
        repeat (900) @(posedge core_clk);
        chk("valid_count", exp_n[15:0], n_valid[15:0]);
        chk("transfer_active", 16'h0000, {15'h0000, transfer_active});
        rd_chk(`PIM_OFS_STATUS, {13'h0000, st}, 16'h0007);
        wr(`PIM_OFS_MODE, mode & 16'hfbff);
        start <= 1'b0;
    endtask

    always @(posedge core_clk) begin
        if (mod_out.valid === 1'b1) begin
            chk("mod_out.data", {8'h00, (8'h31 + 8'(n_valid % 4)) ^ {8{exp_inv}}}, {8'h00, mod_out.data});
            n_valid++;
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #300us;
        err_count++;
        test_done();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        bus_req = '0;
        start = 1'b0;
        bd_fall = 1'b0;
        exp_inv = 1'b0;
        n_valid = 0;
        err_count = 0;
        samples_checked = 0;
        // Mode words carry vidkill set and zero function bits
        rows = '{
            '{4'h0, 16'h0084, 16'h0084, 1'b1, 1'b0},
            '{4'h0, 16'h0085, 16'h0085, 1'b0, 1'b0},
            '{4'h0, 16'h0086, 16'h0086, 1'b1, 1'b0},
            '{4'h0, 16'h0087, 16'h0087, 1'b0, 1'b0},
            '{4'h0, 16'h0088, 16'h0088, 1'b1, 1'b0},
            '{4'h0, 16'h0089, 16'h0089, 1'b0, 1'b0},
            '{4'h0, 16'h008b, 16'h008b, 1'b0, 1'b1},
            '{4'h0, 16'h008c, 16'h008c, 1'b0, 1'b1},
            '{4'h0, 16'h008a, 16'h008a, 1'b0, 1'b0},
            '{4'h1, 16'hffff, 16'h0000, 1'b0, 1'b0},
            '{4'h2, 16'hffff, 16'h07ff, 1'b0, 1'b0},
            '{4'h3, 16'hf5a5, 16'h05a5, 1'b0, 1'b0},
            '{4'h4, 16'hffff, 16'hffff, 1'b0, 1'b0},
            '{4'h5, 16'ha55a, 16'ha55a, 1'b0, 1'b0},
            '{4'h7, 16'h1234, 16'h0000, 1'b0, 1'b0}
        };
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 7; a++) begin
            rd_chk(4'(a), 16'h0000, 16'hffff);
        end
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rexp, 16'hffff);
            chk("enhance", {15'h0000, rows[i].enh}, {15'h0000, mod_out.enhance});
            chk("eight_bit", {15'h0000, rows[i].e8}, {15'h0000, mod_out.eight_bit});
        end
        // Tables first, then the control words
        wr(`PIM_OFS_HMARGIN, 16'h000c);
        wr(`PIM_OFS_LINELEN, 16'h0003);
        wr(`PIM_OFS_VTOP, 16'h0001);
        wr(`PIM_OFS_VBOT, 16'h0003);
        page(16'h0484, 8, 1'b0, 3'h6);
        page(16'h0785, 8, 1'b0, 3'h6);
        page(16'h068c, 8, 1'b1, 3'h6);
        page(16'h008c, 0, 1'b0, 3'h0);
        // Reset in mid-page must stop imaging and clear the arm
        wr(`PIM_OFS_MODE, 16'h0484);
        start <= 1'b1;
        repeat (250) @(posedge core_clk);
        chk("transfer_active", 16'h0001, {15'h0000, transfer_active});
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        n_valid = 0;
        #1;
        chk("transfer_active", 16'h0000, {15'h0000, transfer_active});
        repeat (700) @(posedge core_clk);
        chk("valid_count", 16'h0000, n_valid[15:0]);
        rd_chk(`PIM_OFS_MODE, 16'h0000, 16'hffff);
        test_done();
    end
endmodule
